/* mpc_power_control.sv */
// Functional notes
// - Onboard sequencing starts only while power good is high.
// - Internal reset stays asserted while power good is driven low.
// - Supply-on request goes low whenever the main supply must be on.
// - A button press is an operator request to turn power on or off.
// - The action taken on a button press is selected by configuration.
`timescale 1ns/1ps
`default_nettype none
module mpc_power_control
   import mpc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic power_good_in,
   input wire logic power_button_n,
   input wire logic [1:0] button_action,
   output logic supply_on_request_n,
   output logic module_reset_n,
   output logic sequencing_active,
   output logic power_on
);

   mpc_sync_if sif ();
   mpc_state_t state;
   mpc_state_t next_state;
   logic good_sync;
   logic button_sync_n;
   logic button_prev_n;
   logic press;
   logic press_up;
   logic press_down;
   logic ramp_done;
   logic [MPC_CNT_W-1:0] ramp_count;
   logic next_supply_on_request_n;
   logic next_module_reset_n;
   logic next_sequencing_active;
   logic next_power_on;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisation.

   assign sif.power_good_raw = power_good_in;
   assign sif.power_button_raw_n = power_button_n;

   mpc_input_sync u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .sif(sif)
   );

   // Only these synchronised views of the carrier pins feed any decision below.
   assign good_sync = sif.power_good;
   assign button_sync_n = sif.power_button_n;

   // The previous level resets released, so leaving reset never looks like a press.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         button_prev_n <= 1'h1;
      end else begin
         button_prev_n <= button_sync_n;
      end
   end

   // A press is the falling edge of the synchronised button level.
   assign press = button_prev_n && !button_sync_n;

   ////////////////////////////////////////////////////////////////////////////
   // Button action decode.

   // The configured action decides in which direction a press may switch power.
   always_comb begin
      press_up = 1'h0;
      press_down = 1'h0;
      case (button_action)
         MPC_ACT_TOGGLE: begin
            press_up = press;
            press_down = press;
         end
         MPC_ACT_ON_ONLY: begin
            press_up = press;
         end
         MPC_ACT_OFF_ONLY: begin
            press_down = press;
         end
         MPC_ACT_IGNORE: begin
            press_up = 1'h0;
            press_down = 1'h0;
         end
         default: begin
            press_up = 1'h0;
            press_down = 1'h0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power state sequencing.

   always_comb begin
      next_state = state;
      case (state)
         MPC_OFF: begin
            // Standby only; the supply request is released.
            if (press_up) begin
               next_state = MPC_HOLD;
            end
         end
         MPC_HOLD: begin
            // Supply is requested; wait for power good before sequencing.
            if (good_sync) begin
               next_state = MPC_RAMP;
            end else if (press_down) begin
               next_state = MPC_OFF;
            end
         end
         MPC_RAMP: begin
            // Presses are ignored here so a half-sequenced module is never cut.
            if (!good_sync) begin
               next_state = MPC_HOLD;
            end else if (ramp_done) begin
               next_state = MPC_ON;
            end
         end
         MPC_ON: begin
            // Loss of power good keeps the request so the rails may come back.
            if (press_down) begin
               next_state = MPC_OFF;
            end else if (!good_sync) begin
               next_state = MPC_HOLD;
            end
         end
         default: begin
            next_state = MPC_OFF;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state <= MPC_OFF;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Ramp timer.

   // The timer runs only while the state stays in ramp and restarts on every entry.
   always_ff @(posedge ref_clk) begin
      if (!reset_n || next_state != MPC_RAMP || state != MPC_RAMP) begin
         ramp_count <= '0;
      end else begin
         ramp_count <= ramp_count + MPC_CNT_W'(1);
      end
   end

   assign ramp_done = (ramp_count == MPC_CNT_W'(MPC_RAMP_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////////
   // Output decode.

   // Output levels belong to the state about to be entered, so the pins move with it.
   always_comb begin
      next_supply_on_request_n = 1'h0;
      next_module_reset_n = 1'h0;
      next_sequencing_active = 1'h0;
      next_power_on = 1'h0;
      case (next_state)
         MPC_OFF: begin
            next_supply_on_request_n = 1'h1;
         end
         MPC_HOLD: begin
            next_supply_on_request_n = 1'h0;
         end
         MPC_RAMP: begin
            next_sequencing_active = 1'h1;
         end
         MPC_ON: begin
            next_module_reset_n = good_sync;
            next_power_on = 1'h1;
         end
         default: begin
            next_supply_on_request_n = 1'h1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs.

   // The supply request stays low in every state but off, power loss included.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         supply_on_request_n <= 1'h1;
      end else begin
         supply_on_request_n <= next_supply_on_request_n;
      end
   end

   // The module leaves reset only when fully on and power good still stands.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         module_reset_n <= 1'h0;
      end else begin
         module_reset_n <= next_module_reset_n;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sequencing_active <= 1'h0;
      end else begin
         sequencing_active <= next_sequencing_active;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         power_on <= 1'h0;
      end else begin
         power_on <= next_power_on;
      end
   end

endmodule
`default_nettype wire

/* mpc_pkg.sv */
package mpc_pkg;

   // Power states of the module sequencer.
   typedef enum logic [1:0] {
      MPC_OFF = 2'b00,
      MPC_RAMP = 2'b01,
      MPC_ON = 2'b10,
      MPC_HOLD = 2'b11
   } mpc_state_t;

   // Button action selections.
   localparam logic [1:0] MPC_ACT_TOGGLE = 2'h0;
   localparam logic [1:0] MPC_ACT_ON_ONLY = 2'h1;
   localparam logic [1:0] MPC_ACT_OFF_ONLY = 2'h2;
   localparam logic [1:0] MPC_ACT_IGNORE = 2'h3;

   // Clock rate and sequencing times.
   localparam int MPC_CLK_MHZ = 100;
   localparam int MPC_RAMP_US = 10;
   localparam int MPC_RAMP_CYCLES = MPC_RAMP_US * MPC_CLK_MHZ;
   localparam int MPC_CNT_W = 16;
   localparam int MPC_SYNC_STAGES = 2;

endpackage

/* mpc_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mpc_sync_if;
   logic power_good_raw;
   logic power_button_raw_n;
   logic power_good;
   logic power_button_n;
   modport sync (input power_good_raw, input power_button_raw_n,
      output power_good, output power_button_n);
   modport user (output power_good_raw, output power_button_raw_n,
      input power_good, input power_button_n);
endinterface
`default_nettype wire

/* mpc_input_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module mpc_input_sync
   import mpc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   mpc_sync_if.sync sif
);

   logic [MPC_SYNC_STAGES-1:0] good_pipe;
   logic [MPC_SYNC_STAGES-1:0] button_pipe;

   // Two-stage synchronisers; button idles released (high) after reset.
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         good_pipe <= '0;
         button_pipe <= '1;
      end else begin
         good_pipe <= {good_pipe[MPC_SYNC_STAGES-2:0], sif.power_good_raw};
         button_pipe <= {button_pipe[MPC_SYNC_STAGES-2:0], sif.power_button_raw_n};
      end
   end

   assign sif.power_good = good_pipe[MPC_SYNC_STAGES-1];
   assign sif.power_button_n = button_pipe[MPC_SYNC_STAGES-1];

endmodule
`default_nettype wire

/* mpc_power_control_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module mpc_power_control_asserts
   import mpc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic power_good_in,
   input wire logic power_button_n,
   input wire logic [1:0] button_action,
   input wire logic supply_on_request_n,
   input wire logic module_reset_n,
   input wire logic sequencing_active,
   input wire logic power_on
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   ramp_needs_pg_a: assert property ($rose(sequencing_active) |-> $past(power_good_in, 3))
      else $error("ramp began without power good");
   pg_low_reset_a: assert property (!power_good_in [*6] |-> !module_reset_n)
      else $error("module reset released while power good low");
   reset_only_on_a: assert property (module_reset_n |-> power_on)
      else $error("module reset released outside on state");
   supply_held_a: assert property (power_on || sequencing_active |-> !supply_on_request_n)
      else $error("supply request off while powered");
   press_turns_on_a: assert property ($fell(power_button_n) && supply_on_request_n
      && !power_on && !button_action[1] |-> ##[2:5] !supply_on_request_n)
      else $error("press did not request supply");
   press_turns_off_a: assert property ($fell(power_button_n) && power_on
      && !button_action[0] |-> ##[2:5] supply_on_request_n)
      else $error("press did not drop supply");
   ignore_press_a: assert property ($fell(power_button_n)
      && button_action == MPC_ACT_IGNORE |-> ##1 $stable(supply_on_request_n) [*6])
      else $error("ignored press changed supply");
   sync_delay_a: assert property ($rose(power_good_in) |=> !sequencing_active [*2])
      else $error("power good used before synchroniser");
endmodule
bind mpc_power_control mpc_power_control_asserts u_mpc_power_control_asserts (.ref_clk,
   .reset_n, .power_good_in, .power_button_n, .button_action, .supply_on_request_n,
   .module_reset_n, .sequencing_active, .power_on);
`default_nettype wire

/* mpc_carrier_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mpc_carrier_model #(parameter int PG_DLY = 20) (
   input wire logic ref_clk,
   input wire logic supply_on_request_n,
   input wire logic rail_fault,
   input wire logic press,
   output logic power_good_in,
   output logic power_button_n
);
   int up_cnt = 0;
   int btn_cnt = 0;
   initial power_good_in = 1'b0;
   initial power_button_n = 1'b1;
   // Supply enable is the inverted request; power good waits for settled rails.
   always @(negedge ref_clk) begin
      up_cnt <= (supply_on_request_n === 1'b0 && !rail_fault) ? up_cnt + 1 : 0;
      power_good_in <= (up_cnt >= PG_DLY);
      btn_cnt <= press ? 6 : (btn_cnt > 0 ? btn_cnt - 1 : 0);
      power_button_n <= (btn_cnt == 0);
   end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   import mpc_pkg::*;
   logic ref_clk, reset_n, power_good_in, power_button_n, press, rail_fault, on;
   logic supply_on_request_n, module_reset_n, sequencing_active, power_on;
   logic [1:0] button_action, act;
   logic [15:0] lfsr;
   int n_mismatch = 0;
   int cmp_count = 0;
   int cycles = 0;
   mpc_power_control u_mpc_power_control (.ref_clk(ref_clk), .reset_n(reset_n),
      .power_good_in(power_good_in), .power_button_n(power_button_n),
      .button_action(button_action), .supply_on_request_n(supply_on_request_n),
      .module_reset_n(module_reset_n), .sequencing_active(sequencing_active),
      .power_on(power_on));
   mpc_carrier_model u_mpc_carrier_model (.ref_clk(ref_clk),
      .supply_on_request_n(supply_on_request_n), .rail_fault(rail_fault), .press(press),
      .power_good_in(power_good_in), .power_button_n(power_button_n));
   function automatic logic [15:0] lfsr_next(input logic [15:0] l);
      return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
   endfunction
   function automatic logic next_on(input logic cur, input logic [1:0] a);
      return cur ? !(a == MPC_ACT_TOGGLE || a == MPC_ACT_OFF_ONLY) : !a[1];
   endfunction
   task automatic check(input logic seen, input logic exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: saw %b expected %b", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic press_btn(input logic [1:0] a);
      @(negedge ref_clk) button_action <= a;
      press <= 1'b1;
      @(negedge ref_clk) press <= 1'b0;
      repeat (12) @(negedge ref_clk);
   endtask
   task automatic wait_on();
      int n;
      n = 0;
      if (power_on !== 1'b1) begin
         for (int k = 0; k < 200 && sequencing_active !== 1'b1; k++) @(negedge ref_clk);
         check(sequencing_active, 1'b1);
         check(module_reset_n, 1'b0);
         while (sequencing_active === 1'b1 && n < 1100) begin
            n++;
            @(negedge ref_clk);
         end
         check(n == MPC_RAMP_CYCLES, 1'b1);
      end
      check(power_on, 1'b1);
      check(module_reset_n, 1'b1);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      reset_n = 1'b0;
      press = 1'b0;
      rail_fault = 1'b0;
      button_action = MPC_ACT_IGNORE;
      lfsr = 16'h958E;
      on = 1'b0;
      repeat (6) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      check(supply_on_request_n, 1'b1);
      check(module_reset_n, 1'b0);
      // A second press while waiting for power good withdraws the request.
      press_btn(MPC_ACT_TOGGLE);
      check(supply_on_request_n, 1'b0);
      press_btn(MPC_ACT_TOGGLE);
      check(supply_on_request_n, 1'b1);
      check(sequencing_active, 1'b0);
      $display("test hold cancel done");
      for (int i = 0; i < 10; i++) begin
         lfsr = lfsr_next(lfsr);
         act = (i < 4) ? 2'(i) : lfsr[1:0];
         press_btn(act);
         on = next_on(on, act);
         check(supply_on_request_n, !on);
         if (on) begin
            wait_on();
            if (i == 0) begin
               rail_fault <= 1'b1;
               repeat (8) @(negedge ref_clk);
               check(module_reset_n, 1'b0);
               check(supply_on_request_n, 1'b0);
               rail_fault <= 1'b0;
               wait_on();
            end
         end
         $display("test %0d done", i);
      end
      summarize();
   end
endmodule
`default_nettype wire
